/* File: rtl/cms_deglitch.sv */
// deglitch filter for one synchronised comparator level
`timescale 1ns/1ps
module cms_deglitch #(
  parameter longint CYC = 16,
  parameter bit BOTH = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  localparam int WID = $clog2(CYC + 1);
  logic [WID-1:0] cnt;

  // ------------------------------------------------------------
  // output follows input once it has held for CYC cycles; with BOTH clear a low input is followed at once
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt <= '0;
    end else if (!din && !BOTH) begin
      dout <= 1'b0;
      cnt <= '0;
    end else if (cnt == WID'(CYC - 1)) begin
      dout <= din;
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // cms_deglitch

/* File: rtl/cms_pkg.sv */
// constants and types of the charger mode sequencer
package cms_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_MHZ = 250;
  localparam longint TERM_DEG_US = 43;
  localparam longint VIN_DEG_MS = 30;
  localparam longint ADP_INT_S = 2;
  localparam longint ADP_TEST_US = 10;
  localparam longint RECH_DEG_MS = 130;
  localparam longint REV_DEG_MS = 30;
  localparam longint T32_S = 32;
  localparam longint TERM_DEG_CYC = TERM_DEG_US * CLK_MHZ;
  localparam longint VIN_DEG_CYC = VIN_DEG_MS * 1000 * CLK_MHZ;
  localparam longint ADP_INT_CYC = ADP_INT_S * 1000000 * CLK_MHZ;
  localparam longint ADP_TEST_CYC = ADP_TEST_US * CLK_MHZ;
  localparam longint RECH_DEG_CYC = RECH_DEG_MS * 1000 * CLK_MHZ;
  localparam longint REV_DEG_CYC = REV_DEG_MS * 1000 * CLK_MHZ;
  localparam longint T32_CYC = T32_S * 1000000 * CLK_MHZ;
  // ------------------------------------------------------------
  // serial slave and registers
  // ------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR = 7'h4A;
  localparam int NREG = 5;
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_CFG_A = 4'h1;
  localparam logic [3:0] IDX_CFG_C = 4'h3;
  localparam logic [3:0] IDX_CFG_D = 4'h4;
  localparam logic [3:0] IDX_STATUS_A = 4'h6;
  localparam logic [3:0] IDX_STATUS_B = 4'h7;
  localparam logic [3:0] IDX_FAULT = 4'h9;
  localparam logic [7:0] RST_CONTROL = 8'h0A;
  localparam logic [7:0] RST_CFG_A = 8'h01;
  localparam logic [7:0] RST_CFG_B = 8'h19;
  localparam logic [7:0] RST_CFG_C = 8'h02;
  localparam logic [7:0] RST_CFG_D = 8'h40;
  localparam int LMTSEL_BIT = 7;
  localparam int ICHG_LSB = 3;
  localparam int LOWCHG_BIT = 3;
  localparam int MCHG_LSB = 4;
  localparam logic [1:0] EN_HIZ = 2'h0;
  localparam logic [1:0] EN_BOOST = 2'h1;
  localparam logic [1:0] EN_CHARGE = 2'h2;
  localparam logic [2:0] ST_HIZ = 3'h0;
  localparam logic [2:0] ST_FAST = 3'h1;
  localparam logic [2:0] ST_DONE = 3'h2;
  localparam logic [2:0] ST_BOOST = 3'h3;
  localparam logic [2:0] ST_PRE = 3'h4;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CMS_HIZ = 3'b001,
    CMS_CHARGE = 3'b010,
    CMS_BOOST = 3'b100
  } cms_mode_t;
  typedef struct packed {
    logic term;
    logic vin_ok;
    logic rech_low;
    logic rev_exit_ok;
    logic rev_low;
    logic pre_above;
    logic die_treg;
    logic boost_ovp;
    logic input_overvoltage_threshold;
    logic batt_ovp;
    logic bat_max;
    logic bat_start_ok;
    logic bat_min_low;
    logic det_done;
    logic det_charger;
  } cms_cmp_t;
  typedef struct packed {
    logic input_overvoltage_threshold;
    logic batt_ovp;
    logic bad_adaptor;
    logic boost_ovp;
    logic bat_max;
    logic bat_min;
  } cms_fault_t;
endpackage

/* File: rtl/cms_sequencer.sv */
// charger mode sequencer with serial register slave
//
// Contract
// RULE1 - termination accepted after 43 us stable
// RULE2 - input valid after 30 ms above limit
// RULE3 - adaptor test current every 2 s
// RULE4 - recharge after 130 ms below threshold
// RULE5 - reverse protection exits after 30 ms
// RULE6 - precharge current at or below threshold
// RULE7 - low current select forces fixed current
// RULE8 - thermal regulation reduces current and flags
// RULE9 - 32 second timer while charging
// RULE10 - boost over-voltage stops converter
// RULE11 - input over-voltage stops charging
// RULE12 - battery over-voltage stops charging
// RULE13 - battery too high stops boost
// RULE14 - boost starts above 2.9, stops 2.5
// RULE15 - exactly one of three modes
// RULE16 - high impedance stops charge and boost
// RULE17 - charger detection starts after reset
// RULE18 - host may ignore detection result
// RULE19 - answer only slave address 1001010
// RULE20 - master sends address then direction bit
// RULE21 - second byte index, third byte data
// RULE22 - enable field selects operating mode
// RULE23 - faults clear field, recharge clears 10
// RULE24 - acknowledge address, index and data
// RULE25 - faults set readable status flags
`timescale 1ns/1ps
module cms_sequencer #(
  parameter longint TERM_CYC = cms_pkg::TERM_DEG_CYC,
  parameter longint VIN_CYC = cms_pkg::VIN_DEG_CYC,
  parameter longint RECH_CYC = cms_pkg::RECH_DEG_CYC,
  parameter longint REV_CYC = cms_pkg::REV_DEG_CYC,
  parameter longint ADP_INT_CYC = cms_pkg::ADP_INT_CYC,
  parameter longint ADP_TEST_CYC = cms_pkg::ADP_TEST_CYC,
  parameter longint T32_CYC = cms_pkg::T32_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire cms_pkg::cms_cmp_t cmp,
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_n,
  output cms_pkg::cms_mode_t mode,
  output logic [1:0] charger_enable_field,
  output logic charge_on,
  output logic boost_on,
  output logic precharge_sel,
  output logic low_current_sel,
  output logic [3:0] ichg_code,
  output logic thermal_reg,
  output logic term_done,
  output logic recharge_req,
  output logic input_valid,
  output logic reverse_protect,
  output logic adaptor_test_current,
  output logic t32_tick,
  output logic usb_det_start,
  output logic input_limit_1a,
  output cms_pkg::cms_fault_t fault_flags
);
  localparam int AW = $clog2(ADP_INT_CYC + 1);
  localparam int TW = $clog2(T32_CYC + 1);

  typedef enum logic [8:0] {
    I_IDLE = 9'b000000001,
    I_ADDR = 9'b000000010,
    I_AACK = 9'b000000100,
    I_REG = 9'b000001000,
    I_RACK = 9'b000010000,
    I_WDATA = 9'b000100000,
    I_WACK = 9'b001000000,
    I_RDATA = 9'b010000000,
    I_MACK = 9'b100000000
  } cms_i2c_t;

  cms_pkg::cms_cmp_t cmp_meta;
  cms_pkg::cms_cmp_t cs;
  logic [1:0] scl_meta;
  logic scl_s;
  logic scl_d;
  logic sda_meta;
  logic sda_s;
  logic sda_d;
  logic term_dg;
  logic vin_dg;
  logic rech_dg;
  logic rech_dg_d;
  logic rev_dg;
  cms_i2c_t ist;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic rnw;
  logic [3:0] ptr;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] regs [cms_pkg::NREG];
  logic [7:0] rd_data;
  logic [2:0] chstat;
  logic [AW-1:0] adp_cnt;
  logic adp_bad;
  logic [TW-1:0] t32_cnt;
  logic [3:0] ich;
  logic [3:0] mch;
  logic det_result;
  cms_pkg::cms_fault_t fault_evt;
  logic any_fault;
  logic rech_evt;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic in_chg;
  logic in_bst;
  cms_pkg::cms_mode_t next_mode;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_meta <= '0;
      cs <= '0;
      scl_meta <= 2'h3;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      cmp_meta <= cmp;
      cs <= cmp_meta;
      scl_meta <= {scl_meta[0], i2c_scl};
      scl_d <= scl_s;
      sda_meta <= i2c_sda_in;
      sda_s <= sda_meta;
      sda_d <= sda_s;
    end
  end
  assign scl_s = scl_meta[1];

  // ------------------------------------------------------------
  // deglitch filters
  // ------------------------------------------------------------
  cms_deglitch #(.CYC(TERM_CYC), .BOTH(1'b1)) u_term (
    .clk(clk), .rst(rst), .din(cs.term), .dout(term_dg)); // RULE1
  cms_deglitch #(.CYC(VIN_CYC), .BOTH(1'b0)) u_vin (
    .clk(clk), .rst(rst), .din(cs.vin_ok), .dout(vin_dg)); // RULE2
  cms_deglitch #(.CYC(RECH_CYC), .BOTH(1'b0)) u_rech (
    .clk(clk), .rst(rst), .din(cs.rech_low), .dout(rech_dg)); // RULE4
  cms_deglitch #(.CYC(REV_CYC), .BOTH(1'b0)) u_rev (
    .clk(clk), .rst(rst), .din(cs.rev_exit_ok), .dout(rev_dg)); // RULE5

  // ------------------------------------------------------------
  // bus condition detection
  // ------------------------------------------------------------
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign i2c_start = scl_s && scl_d && sda_d && !sda_s;
  assign i2c_stop = scl_s && scl_d && !sda_d && sda_s;

  // ------------------------------------------------------------
  // serial slave
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist <= I_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      rnw <= 1'b0;
      ptr <= 4'h0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      i2c_sda_oe_n <= 1'b1;
    end else begin
      wr_stb <= 1'b0;
      if (i2c_start) begin
        ist <= I_ADDR; // RULE20
        bitcnt <= 4'h0;
        i2c_sda_oe_n <= 1'b1;
      end else if (i2c_stop) begin
        ist <= I_IDLE;
        i2c_sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (ist == I_MACK) begin
          if (sda_s) begin
            ist <= I_IDLE;
          end
        end else if ((ist == I_ADDR || ist == I_REG || ist == I_WDATA)
                     && bitcnt != 4'h8) begin
          shreg <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
      end else if (scl_fall) begin
        case (ist)
          I_ADDR: begin
            if (bitcnt == 4'h8) begin
              if (shreg[7:1] == cms_pkg::I2C_ADDR) begin // RULE19
                ist <= I_AACK;
                rnw <= shreg[0];
                i2c_sda_oe_n <= 1'b0; // RULE24
              end else begin
                ist <= I_IDLE;
              end
            end
          end
          I_AACK: begin
            bitcnt <= 4'h0;
            if (rnw) begin
              ist <= I_RDATA;
              shreg <= {rd_data[6:0], 1'b0};
              i2c_sda_oe_n <= rd_data[7];
              bitcnt <= 4'h1;
            end else begin
              ist <= I_REG;
              i2c_sda_oe_n <= 1'b1;
            end
          end
          I_REG: begin
            if (bitcnt == 4'h8) begin
              ptr <= shreg[3:0]; // RULE21
              ist <= I_RACK;
              i2c_sda_oe_n <= 1'b0; // RULE24
            end
          end
          I_RACK: begin
            ist <= I_WDATA;
            bitcnt <= 4'h0;
            i2c_sda_oe_n <= 1'b1;
          end
          I_WDATA: begin
            if (bitcnt == 4'h8) begin
              wr_stb <= 1'b1; // RULE21
              wr_data <= shreg;
              ist <= I_WACK;
              i2c_sda_oe_n <= 1'b0; // RULE24
            end
          end
          I_WACK: begin
            ist <= I_WDATA;
            bitcnt <= 4'h0;
            ptr <= ptr + 4'h1;
            i2c_sda_oe_n <= 1'b1;
          end
          I_RDATA: begin
            if (bitcnt == 4'h8) begin
              ist <= I_MACK;
              i2c_sda_oe_n <= 1'b1;
              ptr <= ptr + 4'h1;
            end else begin
              i2c_sda_oe_n <= shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          I_MACK: begin
            ist <= I_RDATA;
            shreg <= {rd_data[6:0], 1'b0};
            i2c_sda_oe_n <= rd_data[7];
            bitcnt <= 4'h1;
          end
          default: begin
            ist <= I_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i2c_sda_out <= 1'b0;
    end else begin
      i2c_sda_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (ptr < 4'(cms_pkg::NREG)) begin
      rd_data = regs[ptr[2:0]];
    end else if (ptr == cms_pkg::IDX_STATUS_A) begin
      rd_data = {3'h0, chstat, 2'h0};
    end else if (ptr == cms_pkg::IDX_STATUS_B) begin
      rd_data = {5'h00, usb_det_start == 1'b0, det_result, 1'b0};
    end else if (ptr == cms_pkg::IDX_FAULT) begin
      rd_data = {1'b0, thermal_reg, fault_flags}; // RULE25
    end
  end

  always_comb begin
    chstat = cms_pkg::ST_HIZ;
    if (mode == cms_pkg::CMS_BOOST) begin
      chstat = cms_pkg::ST_BOOST;
    end else if (mode == cms_pkg::CMS_CHARGE) begin
      if (term_done) begin
        chstat = cms_pkg::ST_DONE;
      end else if (precharge_sel) begin
        chstat = cms_pkg::ST_PRE;
      end else begin
        chstat = cms_pkg::ST_FAST;
      end
    end
  end

  // ------------------------------------------------------------
  // fault and recharge events
  // ------------------------------------------------------------
  assign in_chg = mode == cms_pkg::CMS_CHARGE;
  assign in_bst = mode == cms_pkg::CMS_BOOST;
  assign fault_evt.input_overvoltage_threshold = in_chg && cs.input_overvoltage_threshold; // RULE11
  assign fault_evt.batt_ovp = in_chg && cs.batt_ovp; // RULE12
  assign fault_evt.bad_adaptor = adp_bad;
  assign fault_evt.boost_ovp = in_bst && cs.boost_ovp; // RULE10
  assign fault_evt.bat_max = in_bst && cs.bat_max; // RULE13
  assign fault_evt.bat_min = in_bst && cs.bat_min_low; // RULE14
  assign any_fault = |fault_evt;
  assign rech_evt = rech_dg && !rech_dg_d && term_done; // RULE4

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs[0] <= cms_pkg::RST_CONTROL;
      regs[1] <= cms_pkg::RST_CFG_A;
      regs[2] <= cms_pkg::RST_CFG_B;
      regs[3] <= cms_pkg::RST_CFG_C;
      regs[4] <= cms_pkg::RST_CFG_D;
    end else begin
      if (wr_stb && ptr < 4'(cms_pkg::NREG)) begin
        regs[ptr[2:0]] <= wr_data; // RULE21
      end
      if (any_fault || (rech_evt && regs[0][1:0] == cms_pkg::EN_CHARGE)) begin
        regs[0][1:0] <= cms_pkg::EN_HIZ; // RULE23
      end
    end
  end
  assign charger_enable_field = regs[0][1:0];

  // ------------------------------------------------------------
  // sticky fault flags, cleared by a control write
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_flags <= '0;
    end else if (wr_stb && ptr == cms_pkg::IDX_CONTROL) begin
      fault_flags <= fault_evt; // RULE25
    end else begin
      fault_flags <= fault_flags | fault_evt; // RULE25
    end
  end

  // ------------------------------------------------------------
  // operating mode
  // ------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      cms_pkg::CMS_HIZ: begin
        if (regs[0][1] && vin_dg && !reverse_protect) begin // RULE22
          next_mode = cms_pkg::CMS_CHARGE;
        end else if (regs[0][1:0] == cms_pkg::EN_BOOST && cs.bat_start_ok) begin
          next_mode = cms_pkg::CMS_BOOST; // RULE14
        end
      end
      cms_pkg::CMS_CHARGE: begin
        if (!regs[0][1] || !vin_dg || reverse_protect || any_fault) begin
          next_mode = cms_pkg::CMS_HIZ; // RULE5
        end
      end
      cms_pkg::CMS_BOOST: begin
        if (regs[0][1:0] != cms_pkg::EN_BOOST || any_fault) begin
          next_mode = cms_pkg::CMS_HIZ; // RULE14
        end
      end
      default: begin
        next_mode = cms_pkg::CMS_HIZ;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= cms_pkg::CMS_HIZ;
      charge_on <= 1'b0;
      boost_on <= 1'b0;
    end else begin
      mode <= next_mode; // RULE15
      charge_on <= next_mode == cms_pkg::CMS_CHARGE && !term_done; // RULE16
      boost_on <= next_mode == cms_pkg::CMS_BOOST; // RULE16
    end
  end

  // ------------------------------------------------------------
  // input validity and reverse protection
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_valid <= 1'b0;
      reverse_protect <= 1'b1;
    end else begin
      input_valid <= vin_dg; // RULE2
      if (cs.rev_low) begin
        reverse_protect <= 1'b1; // RULE5
      end else if (rev_dg) begin
        reverse_protect <= 1'b0; // RULE5
      end
    end
  end

  // ------------------------------------------------------------
  // charge phase, current and thermal regulation
  // ------------------------------------------------------------
  assign ich = regs[1][cms_pkg::ICHG_LSB +: 4];
  assign mch = regs[4][cms_pkg::MCHG_LSB +: 4];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      precharge_sel <= 1'b1;
      low_current_sel <= 1'b0;
      ichg_code <= 4'h0;
      thermal_reg <= 1'b0;
    end else begin
      precharge_sel <= !cs.pre_above; // RULE6
      low_current_sel <= regs[3][cms_pkg::LOWCHG_BIT]; // RULE7
      ichg_code <= (ich < mch) ? ich : mch; // RULE7
      thermal_reg <= in_chg && cs.die_treg; // RULE8
    end
  end

  // ------------------------------------------------------------
  // termination and recharge
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      term_done <= 1'b0;
      rech_dg_d <= 1'b0;
      recharge_req <= 1'b0;
    end else begin
      rech_dg_d <= rech_dg;
      recharge_req <= rech_evt; // RULE4
      if (!in_chg || rech_evt) begin
        term_done <= 1'b0;
      end else if (term_dg && !precharge_sel) begin
        term_done <= 1'b1; // RULE1
      end
    end
  end

  // ------------------------------------------------------------
  // bad adaptor detection
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adp_cnt <= '0;
      adaptor_test_current <= 1'b0;
      adp_bad <= 1'b0;
    end else begin
      adp_bad <= 1'b0;
      if (!regs[0][1]) begin
        adp_cnt <= '0;
        adaptor_test_current <= 1'b0;
      end else if (!adaptor_test_current) begin
        if (adp_cnt == AW'(ADP_INT_CYC - 1)) begin
          adp_cnt <= '0;
          adaptor_test_current <= 1'b1; // RULE3
        end else begin
          adp_cnt <= adp_cnt + 1'b1;
        end
      end else if (adp_cnt == AW'(ADP_TEST_CYC - 1)) begin
        adp_cnt <= '0;
        adaptor_test_current <= 1'b0;
        adp_bad <= !cs.vin_ok; // RULE3
      end else begin
        adp_cnt <= adp_cnt + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // 32 second timer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t32_cnt <= '0;
      t32_tick <= 1'b0;
    end else begin
      t32_tick <= 1'b0;
      if (!in_chg) begin
        t32_cnt <= '0;
      end else if (t32_cnt == TW'(T32_CYC - 1)) begin
        t32_cnt <= '0;
        t32_tick <= 1'b1; // RULE9
      end else begin
        t32_cnt <= t32_cnt + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // charger detection after reset
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      usb_det_start <= 1'b1;
      det_result <= 1'b0;
      input_limit_1a <= 1'b0;
    end else begin
      if (usb_det_start && cs.det_done) begin
        usb_det_start <= 1'b0; // RULE17
        det_result <= cs.det_charger; // RULE17
      end
      input_limit_1a <= in_chg && det_result
                        && !regs[1][cms_pkg::LMTSEL_BIT]; // RULE18
    end
  end
endmodule // cms_sequencer

/* File: test/cms_i2c_host.sv */
// behavioural serial bus host for the slave port
`timescale 1ns/1ps
module cms_i2c_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 1'b1;
    w(10);
    scl = 1'b0;
    w(10);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    w(10);
    scl = 1'b1;
    w(10);
    sda_low = 1'b0;
    w(20);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      w(10);
      scl = 1'b1;
      w(10);
      scl = 1'b0;
      w(2);
    end
    sda_low = 1'b0;
    w(8);
    scl = 1'b1;
    w(5);
    ack = (sda === 1'b0);
    w(5);
    scl = 1'b0;
    w(2);
  endtask
endmodule // cms_i2c_host

/* File: test/cms_sequencer_assertions.sv */
// assertion checker for the charger mode sequencer
`timescale 1ns/1ps
module cms_sequencer_assertions #(
  parameter longint VIN_CYC = 50,
  parameter longint REV_CYC = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire cms_pkg::cms_cmp_t cmp,
  input wire cms_pkg::cms_mode_t mode,
  input wire logic [1:0] charger_enable_field,
  input wire logic charge_on,
  input wire logic boost_on,
  input wire logic thermal_reg,
  input wire logic input_valid,
  input wire logic reverse_protect,
  input wire logic t32_tick,
  input wire cms_pkg::cms_fault_t fault_flags
);
  int vc;
  int rc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) vc <= 0;
    else vc <= cmp.vin_ok ? vc + 1 : 0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rc <= 0;
    else rc <= (cmp.rev_exit_ok && !cmp.rev_low) ? rc + 1 : 0;
  end
  sequence s_hiz2;
    mode == cms_pkg::CMS_HIZ ##1 mode == cms_pkg::CMS_HIZ;
  endsequence
  sequence s_chg_ovp;
    mode == cms_pkg::CMS_CHARGE && cmp.input_overvoltage_threshold;
  endsequence
  sequence s_bst_ovp;
    mode == cms_pkg::CMS_BOOST && cmp.boost_ovp;
  endsequence
  a_mode_onehot: assert property ($onehot(mode))
    else $error("mode not one-hot");
  a_hiz_idle: assert property (s_hiz2 |-> !charge_on && !boost_on)
    else $error("converter on in hiz");
  a_input_overvoltage_threshold_trip: assert property (s_chg_ovp |-> ##[1:8] fault_flags.input_overvoltage_threshold)
    else $error("input_overvoltage_threshold not flagged");
  a_boost_ovp_trip: assert property (s_bst_ovp |-> ##[1:8] !boost_on)
    else $error("boost not stopped");
  a_fault_field: assert property ((fault_flags & ~$past(fault_flags)) != 6'h0 |->
    charger_enable_field == cms_pkg::EN_HIZ)
    else $error("fault left field set");
  a_thermal_flag: assert property (thermal_reg |-> $past(mode) == cms_pkg::CMS_CHARGE)
    else $error("thermal flag outside charge");
  a_tick_pulse: assert property (t32_tick |=> !t32_tick)
    else $error("timer tick too long");
  a_vin_deglitch: assert property ($rose(input_valid) |-> vc >= VIN_CYC)
    else $error("input valid too early");
  a_rev_exit: assert property ($fell(reverse_protect) |-> rc >= REV_CYC)
    else $error("reverse exit too early");
endmodule // cms_sequencer_assertions
bind cms_sequencer cms_sequencer_assertions #(.VIN_CYC(VIN_CYC), .REV_CYC(REV_CYC)) u_chk (
  .clk(clk), .rst(rst), .cmp(cmp), .mode(mode), .charger_enable_field(charger_enable_field),
  .charge_on(charge_on), .boost_on(boost_on), .thermal_reg(thermal_reg),
  .input_valid(input_valid), .reverse_protect(reverse_protect), .t32_tick(t32_tick),
  .fault_flags(fault_flags));

/* File: test/cms_sequencer_tb_top.sv */
// self-checking bench of the charger mode sequencer
`timescale 1ns/1ps
module cms_sequencer_tb_top;
  localparam int VIN = 50;
  localparam int REV = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cms_pkg::cms_cmp_t cmp = '0;
  logic scl, sda_low, sda_out, sda_oe_n, a;
  wire logic sda = (sda_low || sda_oe_n === 1'b0) ? 1'b0 : 1'b1;
  cms_pkg::cms_mode_t mode, exp_mode;
  cms_pkg::cms_fault_t flt;
  logic [1:0] fld;
  logic [3:0] ichg;
  logic chg, bst, pre, low, thr, tdn, rrq, ivl, rpr, adp, tck, det, lim;
  int error_cnt = 0;
  int n_compared = 0;
  int exp_field, nt, na;
  always #2 clk = ~clk;
  cms_sequencer #(.TERM_CYC(20), .VIN_CYC(VIN), .RECH_CYC(50), .REV_CYC(REV),
    .ADP_INT_CYC(400), .ADP_TEST_CYC(10), .T32_CYC(300)) uut (
    .clk(clk), .rst(rst), .cmp(cmp), .i2c_scl(scl), .i2c_sda_in(sda), .i2c_sda_out(sda_out),
    .i2c_sda_oe_n(sda_oe_n), .mode(mode), .charger_enable_field(fld), .charge_on(chg),
    .boost_on(bst), .precharge_sel(pre), .low_current_sel(low), .ichg_code(ichg),
    .thermal_reg(thr), .term_done(tdn), .recharge_req(rrq), .input_valid(ivl),
    .reverse_protect(rpr), .adaptor_test_current(adp), .t32_tick(tck),
    .usb_det_start(det), .input_limit_1a(lim), .fault_flags(flt));
  cms_i2c_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] ix, input logic [7:0] d,
    input logic ek);
    host.start();
    host.put({ad, 1'b0}, a);
    chk(8'(a), 8'(ek), "addr ack");
    if (ek) begin
      host.put(ix, a);
      chk(8'(a), 8'h01, "index ack");
      host.put(d, a);
      chk(8'(a), 8'h01, "data ack");
    end
    host.stop();
  endtask
  task automatic modes();
    chk(8'(fld), 8'(exp_field), "field");
    chk(8'(mode), 8'(exp_mode), "mode");
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial begin
    void'($urandom(32'h956C));
    w(3);
    rst = 1'b0;
    exp_field = 2;
    exp_mode = cms_pkg::CMS_HIZ;
    modes();
    chk(8'(det), 8'h01, "det start");
    chk(8'(sda_oe_n), 8'h01, "sda idle");
    cmp.vin_ok = 1'b1;
    w(5 + $urandom % 40);
    cmp.vin_ok = 1'b0;
    w(10);
    chk(8'(ivl), 8'h00, "glitch");
    cmp.vin_ok = 1'b1;
    w(VIN - 3);
    chk(8'(ivl), 8'h00, "early valid");
    w(10);
    chk(8'(ivl), 8'h01, "valid");
    cmp.rev_exit_ok = 1'b1;
    w(REV - 3);
    chk(8'(rpr), 8'h01, "rev early");
    modes();
    w(10);
    chk(8'(rpr), 8'h00, "rev exit");
    exp_mode = cms_pkg::CMS_CHARGE;
    modes();
    chk(8'(chg), 8'h01, "charge on");
    chk(8'(pre), 8'h01, "pre low");
    cmp.pre_above = 1'b1;
    cmp.die_treg = 1'b1;
    w(6);
    chk(8'(pre), 8'h00, "pre high");
    chk(8'(thr), 8'h01, "thermal");
    cmp.die_treg = 1'b0;
    $display("test charge entry done");
    wr(cms_pkg::I2C_ADDR, 8'(cms_pkg::IDX_CFG_C), 8'h0A, 1'b1);
    chk(8'(low), 8'h01, "low sel");
    {nt, na} = 0;
    for (int i = 0; i < 1230; i++) begin
      w(1);
      nt += (i < 1200) ? tck : 0;
      na += adp;
    end
    chk(8'(nt), 8'h04, "ticks");
    chk(8'(na), 8'h1E, "adp cycles");
    chk(8'(flt), 8'h00, "no fault");
    wr(cms_pkg::I2C_ADDR + 7'h01, 8'h00, 8'h01, 1'b0);
    cmp.bat_start_ok = 1'b1;
    wr(cms_pkg::I2C_ADDR, 8'(cms_pkg::IDX_CONTROL), 8'h09, 1'b1);
    exp_field = 1;
    exp_mode = cms_pkg::CMS_BOOST;
    w(10);
    modes();
    chk(8'(bst), 8'h01, "boost on");
    cmp.boost_ovp = 1'b1;
    w(10);
    exp_field = 0;
    exp_mode = cms_pkg::CMS_HIZ;
    modes();
    chk(8'(flt.boost_ovp), 8'h01, "boost flag");
    chk(8'(bst), 8'h00, "boost off");
    cmp.boost_ovp = 1'b0;
    $display("test boost done");
    wr(cms_pkg::I2C_ADDR, 8'(cms_pkg::IDX_CONTROL), 8'h0A, 1'b1);
    exp_field = 2;
    exp_mode = cms_pkg::CMS_CHARGE;
    w(10);
    modes();
    cmp.input_overvoltage_threshold = 1'b1;
    w(10);
    exp_field = 0;
    exp_mode = cms_pkg::CMS_HIZ;
    modes();
    chk(8'(flt.input_overvoltage_threshold), 8'h01, "vin flag");
    chk(8'(chg), 8'h00, "charge off");
    $display("test faults done");
    summarize();
  end
endmodule // cms_sequencer_tb_top
